// ### common/srip_cfg.svh
// constants for the cyclic i/o image packer: byte offsets, codes, apb map
// assumes inclusion from package and design files by bare name
`ifndef SRIP_CFG_SVH
`define SRIP_CFG_SVH

`define SRIP_IN_ASM_INST      8'h64
`define SRIP_OUT_ASM_INST     8'h96
`define SRIP_IN_BYTES         28
`define SRIP_OUT_BYTES        4
`define SRIP_BIT_RUN          0
`define SRIP_BIT_CONN_LOST    1
`define SRIP_BIT_MAJOR        2
`define SRIP_BIT_MINOR        3
`define SRIP_VID_MAX          16'h270F
`define SRIP_MINOR_MON        8'h10
`define SRIP_MINOR_OUT        8'h40
`define SRIP_INST_MAX         8'h18
// apb register byte addresses
`define SRIP_A_CTRL           12'h000
`define SRIP_A_STATUS         12'h004
`define SRIP_A_IRQ_STAT       12'h008
`define SRIP_A_IRQ_MASK       12'h00C
`define SRIP_A_CMD            12'h010
`define SRIP_A_IMG_BASE       12'h100
`define SRIP_A_OUT_IMG        12'h200
`define SRIP_CTRL_RST         32'h0000_0000
`define SRIP_MASK_RST         32'h0000_0000
// interrupt status bits
`define SRIP_IRQ_SNAP         0
`define SRIP_IRQ_CMD          1
`define SRIP_IRQ_BADVID       2
`define SRIP_IRQ_W            3

`endif

// ### common/srip_pkg.sv
// types for the cyclic i/o image packer
// assumes srip_cfg.svh on the include path
`include "srip_cfg.svh"
package srip_pkg;
    // major fault type, one-hot
    typedef enum logic [7:0] {
        SRIP_MF_NONE = 8'h00, SRIP_MF_HW = 8'h01, SRIP_MF_SIN = 8'h02,
        SRIP_MF_SOUT = 8'h04, SRIP_MF_PWR = 8'h08, SRIP_MF_COMM = 8'h10,
        SRIP_MF_CFG = 8'h20, SRIP_MF_TIME = 8'h40, SRIP_MF_PLUG = 8'h80
    } srip_major_t;

    // relay state as presented to the packer
    typedef struct packed {
        logic        run;
        logic        conn_lost;
        logic        major_fault;
        logic        minor_fault;
        logic        verified;
        logic [15:0] config_check_identifier;
        logic [2:0]  major_sel;       // index 0..7 of the fault type
        logic [7:0]  major_code;
        logic        minor_is_output;
        logic [7:0]  minor_instance;
        logic [15:0] minor_code;
        logic [21:0] io_point_value;
        logic [7:0]  plugin_point_value;
        logic [23:0] monitoring_function_state;
        logic [15:0] first_level_logic_state;
        logic [15:0] second_level_logic_state;
        logic [15:0] output_function_state;
        logic [15:0] output_reset_required;
    } srip_state_t;

    // one apb request
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } srip_apb_req_t;
endpackage

// ### hw/srip_image_pack.sv
// combinational packer: state struct into the 28-byte input image
// assumes its input is already a coherent snapshot
`timescale 1ns/1ps
`default_nettype none
`include "srip_cfg.svh"
module srip_image_pack (
    input  wire srip_pkg::srip_state_t st,
    output logic [8*`SRIP_IN_BYTES-1:0] image,
    output logic                        bad_vid
);
    import srip_pkg::*;
    logic [15:0] vid;    // identifier as sent
    logic [7:0]  mtype;  // one-hot major type
    logic [7:0]  ntype;  // minor type code
    logic [7:0]  ninst;  // instance, zero when out of range

    always_comb begin
        // unverified or out-of-range ids collapse to zero
        bad_vid = st.verified && (st.config_check_identifier == 16'h0000 ||
                  st.config_check_identifier > `SRIP_VID_MAX);
        vid = (st.verified && !bad_vid) ? st.config_check_identifier : 16'h0000;
        // one-hot from the index
        mtype = st.major_fault ? (8'h01 << st.major_sel) : SRIP_MF_NONE;
        ntype = !st.minor_fault ? 8'h00 :
                (st.minor_is_output ? `SRIP_MINOR_OUT : `SRIP_MINOR_MON);
        ninst = (st.minor_fault && st.minor_instance != 8'h00 &&
                 st.minor_instance <= `SRIP_INST_MAX) ? st.minor_instance : 8'h00;
        image = '0; // reserved bits stay zero
        image[`SRIP_BIT_RUN]       = st.run;
        image[`SRIP_BIT_CONN_LOST] = st.conn_lost;
        image[`SRIP_BIT_MAJOR]     = st.major_fault;
        image[`SRIP_BIT_MINOR]     = st.minor_fault;
        // little-endian words, high byte at the higher offset
        image[2*8 +: 16]  = vid;
        image[4*8 +: 8]   = st.major_code;
        image[5*8 +: 8]   = mtype;
        image[6*8 +: 8]   = ninst;
        image[7*8 +: 8]   = ntype;
        image[8*8 +: 16]  = st.minor_code;
        image[10*8 +: 22] = st.io_point_value;
        image[13*8 +: 8]  = st.plugin_point_value;
        image[14*8 +: 24] = st.monitoring_function_state;
        image[17*8 +: 16] = st.first_level_logic_state;
        image[19*8 +: 16] = st.second_level_logic_state;
        image[21*8 +: 16] = st.output_function_state;
        image[23*8 +: 16] = st.output_reset_required;
    end
endmodule // srip_image_pack
`default_nettype wire

// ### hw/srip_cmd_unpack.sv
// unpacks the 4-byte output image into 16 network command bits
// assumes a one-cycle write strobe from the same clock domain
`timescale 1ns/1ps
`default_nettype none
`include "srip_cfg.svh"
module srip_cmd_unpack (
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    input  wire logic                         wr,
    input  wire logic [8*`SRIP_OUT_BYTES-1:0] out_image,
    output logic [15:0]                       network_command_bit,
    output logic                              changed
);
    // command register: bytes 0-1 only; bytes 2-3 dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            network_command_bit <= 16'h0000;
            changed             <= 1'b0;
        end else begin
            changed <= wr && (out_image[15:0] != network_command_bit);
            if (wr) begin
                network_command_bit <= out_image[15:0];
            end
        end
    end
endmodule // srip_cmd_unpack
`default_nettype wire

// ### hw/srip_top.sv
// top of the cyclic i/o image packer with apb register access
// assumes relay state inputs arrive asynchronously and are synchronised here
`timescale 1ns/1ps
`default_nettype none
`include "srip_cfg.svh"
module srip_top (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire srip_pkg::srip_state_t relay_state,
    output logic [15:0]                network_command_bit,
    output logic [8*`SRIP_IN_BYTES-1:0] input_image,
    output logic                       image_valid,
    output logic                       irq
);
    import srip_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // input synchronisers
    srip_state_t sync1;     // first stage, read only by sync2
    srip_state_t sync2;     // usable state
    // two stages per bit; a multi-bit field can still tear across stages,
    // which the snapshot below reduces to one cycle's worth
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= relay_state;
            sync2 <= sync1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // packing
    logic [8*`SRIP_IN_BYTES-1:0] next_image; // combinational image
    logic                        bad_vid;    // invalid identifier seen

    srip_image_pack u_pack (
        .st      (sync2),
        .image   (next_image),
        .bad_vid (bad_vid)
    );

    ////////////////////////////////////////////////////////////////////////////
    // apb decode
    logic        acc;      // access phase
    logic        wr_acc;   // write completes this edge
    logic        rd_acc;   // read access phase, pready not required
    logic [31:0] ctrl;     // bit0 freeze, bit1 snapshot request
    logic [31:0] irq_stat; // sticky events
    logic [31:0] irq_mask; // enables
    logic [31:0] out_img;  // last written output image
    logic        cmd_wr;   // strobe into unpacker
    logic        hit;      // address maps to a register

    assign acc    = psel && penable;
    // a write lands only at the edge that completes the transfer
    assign wr_acc = acc && pready && pwrite;
    assign rd_acc = acc && !pwrite;
    assign cmd_wr = wr_acc && (paddr == `SRIP_A_OUT_IMG);

    always_comb begin
        hit = (paddr == `SRIP_A_CTRL) || (paddr == `SRIP_A_STATUS) ||
              (paddr == `SRIP_A_IRQ_STAT) || (paddr == `SRIP_A_IRQ_MASK) ||
              (paddr == `SRIP_A_CMD) || (paddr == `SRIP_A_OUT_IMG) ||
              (paddr >= `SRIP_A_IMG_BASE &&
               paddr < `SRIP_A_IMG_BASE + 12'h01C && paddr[1:0] == 2'b00);
    end

    ////////////////////////////////////////////////////////////////////////////
    // command unpack
    logic cmd_changed; // command bits changed

    srip_cmd_unpack u_cmd (
        .pclk                (pclk),
        .presetn             (presetn),
        .wr                  (cmd_wr),
        .out_image           (pwdata),
        .network_command_bit (network_command_bit),
        .changed             (cmd_changed)
    );

    // keep whole written word for readback
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_img <= 32'h0000_0000;
        end else if (cmd_wr) begin
            out_img <= pwdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control register
    logic snap_req; // one-shot snapshot while frozen
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `SRIP_CTRL_RST;
        end else if (wr_acc && paddr == `SRIP_A_CTRL) begin
            ctrl <= {30'h0, 1'b0, pwdata[0]}; // bit1 self-clears
        end
    end
    assign snap_req = wr_acc && (paddr == `SRIP_A_CTRL) && pwdata[1];

    ////////////////////////////////////////////////////////////////////////////
    // coherent snapshot: the whole image loads in one edge
    logic snap; // capture this edge
    assign snap = !ctrl[0] || snap_req;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            input_image <= '0;
            image_valid <= 1'b0;
        end else begin
            if (snap) begin
                input_image <= next_image;
            end
            image_valid <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupts: set beats clear
    logic [31:0] ev;  // this cycle's events
    always_comb begin
        ev = 32'h0;
        ev[`SRIP_IRQ_SNAP]   = snap_req;
        ev[`SRIP_IRQ_CMD]    = cmd_changed;
        ev[`SRIP_IRQ_BADVID] = bad_vid;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat <= 32'h0;
        end else begin
            if (wr_acc && paddr == `SRIP_A_IRQ_STAT) begin
                irq_stat <= (irq_stat & ~pwdata) | ev;
            end else begin
                irq_stat <= irq_stat | ev;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask <= `SRIP_MASK_RST;
        end else if (wr_acc && paddr == `SRIP_A_IRQ_MASK) begin
            irq_mask <= pwdata & 32'h0000_0007;
        end
    end

    // registered so irq comes from a flop; one cycle behind the status
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat & irq_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data mux
    logic [31:0] next_rdata; // selected word
    logic [4:0]  widx;       // image word index
    always_comb begin
        widx       = 5'(paddr[6:2]);
        next_rdata = 32'h0;
        if (paddr == `SRIP_A_CTRL) begin
            next_rdata = ctrl;
        end else if (paddr == `SRIP_A_STATUS) begin
            // instance number of the input image, constant
            next_rdata = {24'h0, `SRIP_IN_ASM_INST};
        end else if (paddr == `SRIP_A_IRQ_STAT) begin
            next_rdata = irq_stat;
        end else if (paddr == `SRIP_A_IRQ_MASK) begin
            next_rdata = irq_mask;
        end else if (paddr == `SRIP_A_CMD) begin
            next_rdata = {16'h0, network_command_bit};
        end else if (paddr == `SRIP_A_OUT_IMG) begin
            next_rdata = out_img;
        end else if (hit) begin
            next_rdata = input_image[32*widx +: 32];
        end
    end

    // no wait state: the setup edge loads the answer for the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready    <= 1'b0;
            prdata    <= 32'h0;
            pslverr   <= 1'b0;
        end else begin
            if (psel && !penable) begin
                pready    <= 1'b1;
                prdata    <= next_rdata;
                pslverr   <= !hit;
            end else begin
                pready  <= 1'b0;
                pslverr <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
        input_image[7:4] == 4'h0 && input_image[15:8] == 8'h00 &&
        input_image[12*8+6 +: 2] == 2'b00 &&
        input_image[25*8 +: 24] == 24'h0)
        else $error("reserved image bits not zero");
    a_major_onehot: assert property (@(posedge pclk) disable iff (!presetn)
        $onehot0(input_image[5*8 +: 8]))
        else $error("major fault type not one-hot");
    a_vid_range: assert property (@(posedge pclk) disable iff (!presetn)
        input_image[2*8 +: 16] <= 16'h270F)
        else $error("identifier out of range");
    a_minor_type: assert property (@(posedge pclk) disable iff (!presetn)
        input_image[7*8 +: 8] inside {8'h00, 8'h10, 8'h40})
        else $error("minor type illegal");
    a_minor_inst: assert property (@(posedge pclk) disable iff (!presetn)
        input_image[6*8 +: 8] <= 8'h18)
        else $error("minor instance out of range");
    a_snap_run: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl[0] |=> input_image[0] == $past(sync2.run))
        else $error("run bit not captured");
    a_snap_points: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl[0] |=> input_image[10*8 +: 22] == $past(sync2.io_point_value))
        else $error("point echo wrong");
    a_snap_logic: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl[0] |=> input_image[17*8 +: 16] == $past(sync2.first_level_logic_state) &&
        input_image[19*8 +: 16] == $past(sync2.second_level_logic_state))
        else $error("logic echo wrong");
    // completing write to the output image: access cycle with pready high
    sequence s_cmd_write;
        psel && penable && pready && pwrite && paddr == `SRIP_A_OUT_IMG;
    endsequence
    a_cmd_decode: assert property (@(posedge pclk) disable iff (!presetn)
        s_cmd_write |=> network_command_bit == $past(pwdata[15:0]))
        else $error("command bits not decoded");
endmodule // srip_top
`default_nettype wire

// ### sim/srip_ctl_model.sv
// controller-side model: apb master moving cyclic i/o images
// assumes one clock and a slave that answers with pready
`timescale 1ns/1ps
`default_nettype none
module srip_ctl_model (
    input  wire logic        pclk,
    input  wire logic        pready,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata
);
    ////////////////////////////////////////////////////////////////
    // idle bus from time zero
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0000_0000;
    end

    ////////////////////////////////////////////////////////////////
    // one transfer; request held until pready is seen high
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d; // whole words, so a 4-byte image goes in one go
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // wait as long as the slave needs; the bench watchdog catches a dead slave
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        psel    <= 1'b0;
        penable <= 1'b0;
        // released lines show junk, not the last value
        paddr   <= ~a;
        pwdata  <= ~d;
    endtask
endmodule // srip_ctl_model
`default_nettype wire

// ### sim/safety_relay_io_image_packer_tb.sv
// self-checking bench for the cyclic i/o image packer
// assumes srip_cfg.svh on the include path and the controller model
`timescale 1ns/1ps
`default_nettype none
`include "srip_cfg.svh"
module safety_relay_io_image_packer_tb;
    import srip_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        image_valid, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, d;
    logic [15:0] network_command_bit;
    logic [223:0] input_image, w;
    logic [32:0] exp_q[$];       // expected {pslverr, prdata} per read
    srip_state_t st;             // relay state driven into the dut
    int          errors, checks, seed;

    srip_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .relay_state(st),
        .network_command_bit(network_command_bit), .input_image(input_image),
        .image_valid(image_valid), .irq(irq));
    srip_ctl_model i_ctl (.pclk(pclk), .pready(pready), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

    ////////////////////////////////////////////////////////////////
    // 200 MHz clock
    initial pclk = 1'b0;
    always #2.5 pclk = ~pclk;

    ////////////////////////////////////////////////////////////////
    // one comparison, counted
    task automatic chk(input logic [32:0] got, input logic [32:0] e, input string what);
        checks++;
        if (got !== e) begin
            errors++;
            $display("Error at %0t: %s got %h want %h", $time, what, got, e);
        end
    endtask

    // expected image worked out from the state, reserved bits zero
    function automatic logic [223:0] pack(input srip_state_t s);
        logic [223:0] m;
        logic         ok;
        m = '0;
        ok = s.verified && s.config_check_identifier != 16'h0000
            && s.config_check_identifier <= `SRIP_VID_MAX;
        m[3:0] = {s.minor_fault, s.major_fault, s.conn_lost, s.run};
        m[16+:16] = ok ? s.config_check_identifier : 16'h0000;
        m[40+:8] = s.major_fault ? 8'h01 << s.major_sel : 8'h00;
        m[32+:8] = s.major_code;
        m[56+:8] = !s.minor_fault ? 8'h00 : s.minor_is_output ? `SRIP_MINOR_OUT
            : `SRIP_MINOR_MON;
        m[48+:8] = (s.minor_instance != 8'h00 && s.minor_instance <= `SRIP_INST_MAX)
            ? s.minor_instance : 8'h00;
        m[64+:16] = s.minor_code;
        m[80+:22] = s.io_point_value;
        m[104+:8] = s.plugin_point_value;
        m[112+:24] = s.monitoring_function_state;
        m[136+:16] = s.first_level_logic_state;
        m[152+:16] = s.second_level_logic_state;
        m[168+:16] = s.output_function_state;
        m[184+:16] = s.output_reset_required;
        return m;
    endfunction

    // random state; k picks fault type and an identifier boundary
    task automatic new_state(input int k);
        logic [191:0] r;
        srip_state_t  s;
        r = {$random(seed), $random(seed), $random(seed),
             $random(seed), $random(seed), $random(seed)};
        s = srip_state_t'(r[$bits(srip_state_t)-1:0]);
        s.major_sel = 3'(k);
        s.config_check_identifier = (k % 4 == 0) ? 16'h0000 : (k % 4 == 1) ? 16'h0001
            : (k % 4 == 2) ? `SRIP_VID_MAX : 16'h2710;
        s.minor_instance = {3'h0, s.minor_instance[4:0]};
        // no fault, no fault detail: keeps the expectation unambiguous
        if (!s.major_fault) s.major_code = 8'h00;
        if (!s.minor_fault) begin
            s.minor_is_output = 1'b0;
            s.minor_instance = 8'h00;
            s.minor_code = 16'h0000;
        end
        @(posedge pclk);
        st <= s;
        repeat (5) @(posedge pclk);
    endtask

    // bus helpers; reads leave their expectation in the queue
    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        i_ctl.xfer(1'b0, a, 32'h0000_0000);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        i_ctl.xfer(1'b1, a, v);
    endtask
    task automatic img_chk(input logic [223:0] e, input logic bus);
        @(negedge pclk);
        for (int n = 0; n < `SRIP_IN_BYTES / 4; n++) begin
            chk({1'b0, input_image[32*n+:32]}, {1'b0, e[32*n+:32]}, "image word");
            if (bus) rd(`SRIP_A_IMG_BASE + 12'(4 * n), {1'b0, e[32*n+:32]});
        end
    endtask
    // sel 0 looks at the command bits, 1 at irq, sampled after they settle
    task automatic port_chk(input int sel, input logic [32:0] e, input string s);
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        chk(sel ? {32'h0, irq} : {17'h0, network_command_bit}, e, s);
    endtask

    ////////////////////////////////////////////////////////////////
    // monitor: each completed read takes the oldest expectation
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && pwrite === 1'b0) begin
            if (exp_q.size() == 0) chk({pslverr, prdata}, 33'h1_FFFF_FFFF, "stray read");
            else chk({pslverr, prdata}, exp_q.pop_front(), "read data");
        end
    end

    task automatic end_of_test;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // watchdog well beyond the expected run
    initial begin
        #200000;
        errors++;
        end_of_test();
    end

    ////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        presetn = 1'b0;
        st = '0;
        errors = 0;
        checks = 0;
        seed = 34;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk({31'h0, image_valid, irq}, 33'h0, "outputs low before first edge");
        @(negedge pclk);
        chk({31'h0, image_valid, irq}, 33'h2, "valid and irq after reset");
        rd(`SRIP_A_STATUS, {25'h0, `SRIP_IN_ASM_INST});
        rd(`SRIP_A_CTRL, {1'b0, `SRIP_CTRL_RST});
        rd(`SRIP_A_IRQ_MASK, {1'b0, `SRIP_MASK_RST});
        rd(12'h300, 33'h1_0000_0000);
        $display("test reset done");
        // every fault type and identifier boundary
        for (int k = 0; k < 12; k++) begin
            new_state(k);
            img_chk(pack(st), k < 3);
        end
        $display("test image layout done");
        // frozen image holds one coherent capture
        wr(`SRIP_A_CTRL, 32'h0000_0001);
        w = pack(st);
        new_state(21);
        img_chk(w, 1'b0);
        wr(`SRIP_A_CTRL, 32'h0000_0003);
        rd(`SRIP_A_CTRL, 33'h0_0000_0001);
        img_chk(pack(st), 1'b1);
        wr(`SRIP_A_CTRL, 32'h0000_0000);
        $display("test freeze done");
        // commands, reserved bytes ignored, bit 15 included
        for (int j = 0; j < 5; j++) begin
            d = (j == 0) ? 32'hA5A5_8001 : (j == 1) ? 32'h5A5A_8001 : $random(seed);
            wr(`SRIP_A_OUT_IMG, d);
            port_chk(0, {17'h0, d[15:0]}, "command bits");
            rd(`SRIP_A_CMD, {17'h0, d[15:0]});
        end
        $display("test commands done");
        // command-change interrupt: masked, raised, cleared
        wr(`SRIP_A_IRQ_MASK, 32'h0000_0000);
        wr(`SRIP_A_IRQ_STAT, 32'h0000_0007);
        rd(`SRIP_A_IRQ_STAT, 33'h0_0000_0000);
        wr(`SRIP_A_OUT_IMG, 32'h0000_1234);
        port_chk(1, 33'h0, "irq masked");
        rd(`SRIP_A_IRQ_STAT, 33'h0_0000_0002);
        wr(`SRIP_A_IRQ_MASK, 32'h0000_0002);
        port_chk(1, 33'h1, "irq raised");
        wr(`SRIP_A_IRQ_STAT, 32'h0000_0002);
        port_chk(1, 33'h0, "irq cleared");
        wr(`SRIP_A_OUT_IMG, 32'hFFFF_1234);
        port_chk(1, 33'h0, "no change no irq");
        $display("test interrupt done");
        repeat (4) @(posedge pclk);
        chk({32'h0, exp_q.size() == 0}, 33'h1, "reads answered");
        end_of_test();
    end
endmodule // safety_relay_io_image_packer_tb
`default_nettype wire
